/* design/dpbrf_pkg.sv */
package dpbrf_pkg;
	// ************************************************************
	// array geometry
	// ************************************************************
	localparam int unsigned BANKS = 8;
	localparam int unsigned ROWS = 512;
	localparam int unsigned UNIT_AW = 12;
	localparam int unsigned UNIT_W = 9;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned ADDR_W = 15;
	localparam int unsigned DATA_W = 72;
	localparam int unsigned PAR_LSB = 64;
	// address bit that picks the tile in a cascaded pair
	localparam int unsigned CASC_BIT = 15;

	// ************************************************************
	// fifo depths in 9-bit units
	// ************************************************************
	localparam logic [12:0] FULL_DEPTH = 13'h1000;
	localparam logic [12:0] HALF_DEPTH = 13'h0800;
	localparam logic [11:0] FULL_PMASK = 12'hfff;
	localparam logic [11:0] HALF_PMASK = 12'h7ff;

	// ************************************************************
	// error correction code
	// ************************************************************
	localparam int unsigned ECC_DW = 64;
	localparam int unsigned ECC_CW = 8;
	localparam int unsigned ECC_SW = 7;
	localparam int unsigned ECC_POS_MAX = 71;

	// ************************************************************
	// port shapes and write policies
	// ************************************************************
	typedef enum logic [2:0] {
		W1 = 3'h0,
		W2 = 3'h1,
		W4 = 3'h2,
		W9 = 3'h3,
		W18 = 3'h4,
		W36 = 3'h5,
		W72 = 3'h6
	} dpbrf_width_type;

	typedef enum logic [1:0] {
		READ_FIRST = 2'h0,
		WRITE_FIRST = 2'h1,
		NO_CHANGE = 2'h2
	} dpbrf_wmode_type;
endpackage : dpbrf_pkg

/* design/dpbrf_secded.sv */
`timescale 1ns/1ps
module dpbrf_secded import dpbrf_pkg::*; (
	input wire logic [ECC_DW-1:0] enc_data,
	output logic [ECC_CW-1:0] enc_check,
	input wire logic [ECC_DW-1:0] dec_data,
	input wire logic [ECC_CW-1:0] dec_check,
	output logic [ECC_DW-1:0] dec_fixed,
	output logic dec_sbe,
	output logic dec_dbe
);
	// ************************************************************
	// hamming positions
	// ************************************************************
	// data sits on codeword positions that are not powers of two
	function automatic logic [ECC_SW-1:0] syndrome(input logic [ECC_DW-1:0] d);
		logic [ECC_SW-1:0] s;
		int j;
		s = '0;
		j = 0;
		for (int p = 1; p <= ECC_POS_MAX; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[j]) begin
					s = s ^ ECC_SW'(p);
				end
				j++;
			end
		end
		return s;
	endfunction : syndrome

	logic [ECC_SW-1:0] enc_syn;
	logic [ECC_SW-1:0] dec_syn;
	logic dec_odd;

	// encoder: seven hamming bits plus overall parity on top
	assign enc_syn = syndrome(enc_data);
	assign enc_check = {^enc_data ^ ^enc_syn, enc_syn};

	// decoder: odd total parity means one flipped bit
	assign dec_syn = syndrome(dec_data) ^ dec_check[ECC_SW-1:0];
	assign dec_odd = ^{dec_data, dec_check};
	assign dec_sbe = dec_odd;
	assign dec_dbe = !dec_odd && (dec_syn != '0);

	// flip the data bit the syndrome points at; check-bit hits need no fix
	always_comb begin
		int j;
		j = 0;
		dec_fixed = dec_data;
		for (int p = 1; p <= ECC_POS_MAX; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (dec_odd && dec_syn == ECC_SW'(p)) begin
					dec_fixed[j] = ~dec_data[j];
				end
				j++;
			end
		end
	end
endmodule : dpbrf_secded

/* design/dpbrf_tile.sv */
`timescale 1ns/1ps
module dpbrf_tile import dpbrf_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic split_mode,
	input wire logic one_read_one_write_mode,
	input wire logic fifo_mode,
	input wire logic ecc_en,
	input wire logic addr_latch_off,
	input wire logic sleep,
	input wire logic casc_en,
	input wire logic casc_upper,
	input wire logic a_en,
	input wire logic a_we,
	input wire logic [ADDR_W:0] a_addr,
	input wire logic [DATA_W-1:0] a_din,
	input wire dpbrf_width_type a_width,
	input wire dpbrf_wmode_type a_wmode,
	input wire logic a_out_reg,
	input wire logic [DATA_W-1:0] a_casc_in,
	output logic [DATA_W-1:0] a_dout,
	output logic [DATA_W-1:0] a_casc_out,
	input wire logic b_en,
	input wire logic b_we,
	input wire logic [ADDR_W:0] b_addr,
	input wire logic [DATA_W-1:0] b_din,
	input wire dpbrf_width_type b_width,
	input wire dpbrf_wmode_type b_wmode,
	input wire logic b_out_reg,
	input wire logic [DATA_W-1:0] b_casc_in,
	output logic [DATA_W-1:0] b_dout,
	output logic [DATA_W-1:0] b_casc_out,
	output logic ecc_sbe,
	output logic ecc_dbe,
	input wire logic [12:0] prog_full_thresh,
	input wire logic [12:0] prog_empty_thresh,
	output logic fifo_full,
	output logic fifo_empty,
	output logic fifo_prog_full,
	output logic fifo_prog_empty,
	input wire logic [ECC_DW-1:0] ext_enc_data,
	output logic [ECC_CW-1:0] ext_enc_check,
	input wire logic [ECC_DW-1:0] ext_dec_data,
	input wire logic [ECC_CW-1:0] ext_dec_check,
	output logic [ECC_DW-1:0] ext_dec_fixed,
	output logic ext_sbe,
	output logic ext_dbe
);
	// ************************************************************
	// shape decoding
	// ************************************************************
	function automatic logic [3:0] units_of(input dpbrf_width_type w);
		unique case (w)
			W18: return 4'h2;
			W36: return 4'h4;
			W72: return 4'h8;
			default: return 4'h1;
		endcase
	endfunction : units_of

	function automatic logic [UNIT_AW-1:0] unit_index(input dpbrf_width_type w,
			input logic [ADDR_W-1:0] a);
		unique case (w)
			W1: return a[14:3];
			W2: return a[13:2];
			W4: return a[12:1];
			W9: return a[11:0];
			W18: return {a[10:0], 1'b0};
			W36: return {a[9:0], 2'b00};
			default: return {a[8:0], 3'b000};
		endcase
	endfunction : unit_index

	function automatic logic [2:0] bit_lsb(input dpbrf_width_type w,
			input logic [ADDR_W-1:0] a);
		unique case (w)
			W1: return a[2:0];
			W2: return {a[1:0], 1'b0};
			W4: return {a[0], 2'b00};
			default: return 3'h0;
		endcase
	endfunction : bit_lsb

	function automatic logic [BYTE_W-1:0] width_mask(input dpbrf_width_type w);
		unique case (w)
			W1: return 8'h01;
			W2: return 8'h03;
			W4: return 8'h0f;
			default: return 8'hff;
		endcase
	endfunction : width_mask

	// narrow shapes use the data bits only, wide ones carry parity at bit 64 up
	function automatic logic [DATA_W-1:0] extract(input logic [BANKS-1:0][UNIT_W-1:0] u,
			input dpbrf_width_type w, input logic [2:0] lsb);
		logic [DATA_W-1:0] r;
		r = '0;
		if (w < W9) begin
			r[BYTE_W-1:0] = (u[0][BYTE_W-1:0] >> lsb) & width_mask(w);
		end else begin
			for (int k = 0; k < BANKS; k++) begin
				if (4'(k) < units_of(w)) begin
					r[k*BYTE_W +: BYTE_W] = u[k][BYTE_W-1:0];
					r[PAR_LSB+k] = u[k][BYTE_W];
				end
			end
		end
		return r;
	endfunction : extract

	// wide shapes capped outside the wide mode
	function automatic dpbrf_width_type eff_width(input logic p, input dpbrf_width_type w,
			input dpbrf_width_type cap, input logic wide_mode);
		if (wide_mode && !p) begin
			return cap;
		end
		return (w > cap) ? cap : w;
	endfunction : eff_width

	// ************************************************************
	// port gathering
	// ************************************************************
	logic [1:0] in_en, in_we, in_oreg;
	logic [ADDR_W:0] in_addr [2];
	logic [DATA_W-1:0] in_din [2];
	logic [DATA_W-1:0] in_casc [2];
	dpbrf_width_type in_wid [2];
	dpbrf_wmode_type in_wmode [2];
	dpbrf_width_type cap;
	logic wide_mode;

	assign in_en = {b_en, a_en};
	assign in_oreg = {b_out_reg, a_out_reg};
	assign in_addr[0] = a_addr;
	assign in_addr[1] = b_addr;
	assign in_din[0] = a_din;
	assign in_din[1] = b_din;
	assign in_casc[0] = a_casc_in;
	assign in_casc[1] = b_casc_in;
	assign in_wid[0] = a_width;
	assign in_wid[1] = b_width;
	assign in_wmode[0] = a_wmode;
	assign in_wmode[1] = b_wmode;
	// fifo and wide mode: port a only writes, port b only reads
	assign wide_mode = one_read_one_write_mode | fifo_mode;
	assign in_we = wide_mode ? 2'b01 : {b_we, a_we};
	assign cap = (wide_mode && !split_mode) ? W72 : W36;

	// ************************************************************
	// input capture
	// ************************************************************
	logic [1:0] en_q, we_q;
	logic [ADDR_W:0] addr_q [2];
	logic [DATA_W-1:0] din_q [2];
	dpbrf_width_type wid_q [2];
	dpbrf_wmode_type wmode_q [2];

	// all request inputs but in_oreg registered; sleep blocks new accesses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_q <= 2'b00;
			we_q <= 2'b00;
			for (int p = 0; p < 2; p++) begin
				addr_q[p] <= '0;
				din_q[p] <= '0;
				wid_q[p] <= W9;
				wmode_q[p] <= READ_FIRST;
			end
		end else begin
			en_q <= in_en & {2{~sleep}};
			we_q <= in_we;
			for (int p = 0; p < 2; p++) begin
				din_q[p] <= in_din[p];
				wid_q[p] <= eff_width(p[0], in_wid[p], cap, wide_mode);
				wmode_q[p] <= in_wmode[p];
				// address kept until the next access
				if (in_en[p] || addr_latch_off) begin
					addr_q[p] <= in_addr[p];
				end
			end
		end
	end

	// ************************************************************
	// storage and per-port datapath
	// ************************************************************
	// eight banks of 512 nine-bit units, 36864 bits in all
	logic [UNIT_W-1:0] mem [BANKS][ROWS];
	logic [UNIT_AW-1:0] ptr_q [2];
	logic [UNIT_AW-1:0] unit [2];
	logic [3:0] nun [2];
	logic [2:0] lsb [2];
	logic [BANKS-1:0][UNIT_W-1:0] old_u [2];
	logic [BANKS-1:0][UNIT_W-1:0] new_u [2];
	logic [DATA_W-1:0] rd_word [2];
	logic [DATA_W-1:0] rd_fix [2];
	logic [DATA_W-1:0] own_d [2];
	logic [DATA_W-1:0] own_q [2];
	logic [DATA_W-1:0] dout_q [2];
	logic [1:0] hit, acc, wr_go, sel_q;
	logic [1:0] fifo_ok;
	logic [ECC_CW-1:0] enc_check;
	logic [ECC_DW-1:0] dec_fixed;
	logic dec_sbe, dec_dbe, ecc_wr, ecc_rd;

	for (genvar p = 0; p < 2; p++) begin : g_path
		logic [UNIT_AW-1:0] ua;
		// shape turns the address into a unit index
		assign ua = unit_index(wid_q[p], addr_q[p][ADDR_W-1:0]);
		// split halves: each port owns one half
		assign unit[p] = fifo_mode ? ptr_q[p] :
			split_mode ? {1'(p), ua[UNIT_AW-2:0]} : ua;
		assign nun[p] = units_of(wid_q[p]);
		assign lsb[p] = bit_lsb(wid_q[p], addr_q[p][ADDR_W-1:0]);
		// upper or lower tile of a cascaded pair
		assign hit[p] = !casc_en || (addr_q[p][CASC_BIT] == casc_upper);
		assign acc[p] = en_q[p] & hit[p] & (fifo_ok[p] | ~fifo_mode);
		assign wr_go[p] = acc[p] & we_q[p];

		// every shape reads through the same unit grid
		for (genvar k = 0; k < BANKS; k++) begin : g_bank
			assign old_u[p][k] = mem[3'(unit[p][2:0] + 3'(k))][unit[p][UNIT_AW-1:3]];
		end
		assign rd_word[p] = extract(old_u[p], wid_q[p], lsb[p]);

		// narrow writes merge into the unit, parity bit kept
		always_comb begin
			for (int k = 0; k < BANKS; k++) begin
				new_u[p][k] = {din_q[p][PAR_LSB+k], din_q[p][k*BYTE_W +: BYTE_W]};
				// check bits take the parity slots
				if (p == 0 && ecc_wr) begin
					new_u[p][k][BYTE_W] = enc_check[k];
				end
			end
			if (wid_q[p] < W9) begin
				new_u[p][0] = {old_u[p][0][BYTE_W],
					(old_u[p][0][BYTE_W-1:0] & ~(width_mask(wid_q[p]) << lsb[p])) |
					((din_q[p][BYTE_W-1:0] & width_mask(wid_q[p])) << lsb[p])};
			end
		end

		always_comb begin
			own_d[p] = own_q[p];
			if (acc[p] && (!we_q[p] || wmode_q[p] == READ_FIRST)) begin
				own_d[p] = rd_fix[p];
			end else if (acc[p] && wmode_q[p] == WRITE_FIRST) begin
				own_d[p] = extract(new_u[p], wid_q[p], lsb[p]);
			end
		end
	end

	// corrected read data on the read port
	assign ecc_wr = ecc_en && wid_q[0] == W72;
	assign ecc_rd = ecc_en && wid_q[1] == W72;
	assign rd_fix[0] = rd_word[0];
	assign rd_fix[1] = ecc_rd ? {rd_word[1][DATA_W-1:PAR_LSB], dec_fixed} : rd_word[1];

	// port b wins when both ports write the same unit
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < BANKS; k++) begin
				if (wr_go[p] && 4'(k) < nun[p]) begin
					mem[3'(unit[p][2:0] + 3'(k))][unit[p][UNIT_AW-1:3]] <= new_u[p][k];
				end
			end
		end
	end

	dpbrf_secded u_tile_ecc (
		.enc_data(din_q[0][ECC_DW-1:0]),
		.enc_check(enc_check),
		.dec_data(rd_word[1][ECC_DW-1:0]),
		.dec_check(rd_word[1][DATA_W-1:PAR_LSB]),
		.dec_fixed(dec_fixed),
		.dec_sbe(dec_sbe),
		.dec_dbe(dec_dbe)
	);

	// ************************************************************
	// output stage
	// ************************************************************
	logic sbe1_q, dbe1_q, sbe1_d, dbe1_d, err_go, b_late;

	assign err_go = acc[1] & ~we_q[1] & ecc_rd;
	// separate single and double error flags per read
	assign sbe1_d = err_go ? dec_sbe : sbe1_q;
	assign dbe1_d = err_go ? dec_dbe : dbe1_q;
	assign b_late = casc_en | in_oreg[1];

	// cascade always costs the extra stage: the neighbour's data is a flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_q <= 2'b11;
			sbe1_q <= 1'b0;
			dbe1_q <= 1'b0;
			ecc_sbe <= 1'b0;
			ecc_dbe <= 1'b0;
			for (int p = 0; p < 2; p++) begin
				own_q[p] <= '0;
				dout_q[p] <= '0;
			end
		end else begin
			sbe1_q <= sbe1_d;
			dbe1_q <= dbe1_d;
			ecc_sbe <= b_late ? sbe1_q : sbe1_d;
			ecc_dbe <= b_late ? dbe1_q : dbe1_d;
			for (int p = 0; p < 2; p++) begin
				own_q[p] <= own_d[p];
				if (en_q[p]) begin
					sel_q[p] <= hit[p];
				end
				// pick own or neighbour read data
				if (casc_en) begin
					dout_q[p] <= sel_q[p] ? own_q[p] : in_casc[p];
				end else if (in_oreg[p]) begin
					dout_q[p] <= own_q[p];
				end else begin
					dout_q[p] <= own_d[p];
				end
			end
		end
	end

	assign a_dout = dout_q[0];
	assign b_dout = dout_q[1];
	assign a_casc_out = own_q[0];
	assign b_casc_out = own_q[1];

	// ************************************************************
	// fifo controller
	// ************************************************************
	logic [12:0] cnt_q, cnt_d, depth, wn, rn;
	logic [UNIT_AW-1:0] pmask;
	logic fifo_wr, fifo_rd;

	// each side steps by its own width
	assign wn = 13'(units_of(wid_q[0]));
	assign rn = 13'(units_of(wid_q[1]));
	assign depth = split_mode ? HALF_DEPTH : FULL_DEPTH;
	assign pmask = split_mode ? HALF_PMASK : FULL_PMASK;
	// no write when full, no read when empty
	assign fifo_ok = {~fifo_empty, ~fifo_full};
	assign fifo_wr = fifo_mode & acc[0];
	assign fifo_rd = fifo_mode & acc[1];
	assign cnt_d = cnt_q + (fifo_wr ? wn : 13'h0000) - (fifo_rd ? rn : 13'h0000);

	// pointers and flags kept by the controller
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr_q[0] <= '0;
			ptr_q[1] <= '0;
			cnt_q <= '0;
			fifo_full <= 1'b0;
			fifo_empty <= 1'b1;
			fifo_prog_full <= 1'b0;
			fifo_prog_empty <= 1'b1;
		end else begin
			if (fifo_wr) begin
				ptr_q[0] <= (ptr_q[0] + wn[UNIT_AW-1:0]) & pmask;
			end
			if (fifo_rd) begin
				ptr_q[1] <= (ptr_q[1] + rn[UNIT_AW-1:0]) & pmask;
			end
			cnt_q <= cnt_d;
			fifo_full <= (cnt_d + wn) > depth;
			fifo_empty <= cnt_d < rn;
			// thresholds compared with the fill count
			fifo_prog_full <= cnt_d >= prog_full_thresh;
			fifo_prog_empty <= cnt_d <= prog_empty_thresh;
		end
	end

	// ************************************************************
	// standalone codec
	// ************************************************************
	logic [ECC_CW-1:0] x_check;
	logic [ECC_DW-1:0] x_fixed;
	logic x_sbe, x_dbe;

	dpbrf_secded u_ext_ecc (
		.enc_data(ext_enc_data),
		.enc_check(x_check),
		.dec_data(ext_dec_data),
		.dec_check(ext_dec_check),
		.dec_fixed(x_fixed),
		.dec_sbe(x_sbe),
		.dec_dbe(x_dbe)
	);

	// one cycle through the codec, outputs registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_enc_check <= '0;
			ext_dec_fixed <= '0;
			ext_sbe <= 1'b0;
			ext_dbe <= 1'b0;
		end else begin
			ext_enc_check <= x_check;
			ext_dec_fixed <= x_fixed;
			ext_sbe <= x_sbe;
			ext_dbe <= x_dbe;
		end
	end
endmodule : dpbrf_tile

/* tb/dpbrf_tile_chk.sv */
`timescale 1ns/1ps
// ********************************
// port checker for the memory tile
// ********************************
module dpbrf_tile_chk import dpbrf_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic one_read_one_write_mode,
	input wire logic fifo_mode,
	input wire logic sleep,
	input wire logic casc_en,
	input wire logic a_en,
	input wire logic a_we,
	input wire dpbrf_wmode_type a_wmode,
	input wire logic a_out_reg,
	input wire logic [DATA_W-1:0] a_dout,
	input wire logic b_en,
	input wire logic [DATA_W-1:0] b_dout,
	input wire logic ecc_sbe,
	input wire logic ecc_dbe,
	input wire logic [12:0] prog_full_thresh,
	input wire logic [12:0] prog_empty_thresh,
	input wire logic fifo_full,
	input wire logic fifo_empty,
	input wire logic fifo_prog_full,
	input wire logic fifo_prog_empty,
	input wire logic [ECC_DW-1:0] ext_enc_data,
	input wire logic [ECC_CW-1:0] ext_enc_check,
	input wire logic [ECC_DW-1:0] ext_dec_data,
	input wire logic [ECC_CW-1:0] ext_dec_check,
	input wire logic [ECC_DW-1:0] ext_dec_fixed,
	input wire logic ext_sbe,
	input wire logic ext_dbe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// plain write with no pipeline stage in the way
	sequence s_nc_write;
		a_en && a_we && a_wmode == NO_CHANGE && !a_out_reg && !sleep && !casc_en
			&& !fifo_mode && !one_read_one_write_mode;
	endsequence
	// four cycles let both output stages drain
	sequence s_asleep;
		(sleep && !casc_en) [*4];
	endsequence

	property p_nc_hold;
		s_nc_write |-> ##2 $stable(a_dout);
	endproperty
	a_nc_hold: assert property (p_nc_hold) else $error("port a output moved");
	property p_sleep_hold;
		s_asleep |=> $stable(a_dout) && $stable(b_dout);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("output moved asleep");
	property p_full_hold;
		fifo_mode && fifo_full && !$past(b_en) |=> fifo_full;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full dropped");
	property p_empty_hold;
		fifo_mode && fifo_empty && !$past(a_en) |=> fifo_empty;
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("empty dropped");
	property p_pfull;
		fifo_mode && fifo_full && prog_full_thresh <= 13'h07f0 |-> fifo_prog_full;
	endproperty
	a_pfull: assert property (p_pfull) else $error("full without prog full");
	property p_pempty;
		fifo_mode && fifo_empty && prog_empty_thresh >= 13'h0008 |-> fifo_prog_empty;
	endproperty
	a_pempty: assert property (p_pempty) else $error("empty without prog empty");
	property p_ecc_excl;
		!(ecc_sbe && ecc_dbe);
	endproperty
	a_ecc_excl: assert property (p_ecc_excl) else $error("both tile flags set");
	property p_ext_excl;
		!(ext_sbe && ext_dbe);
	endproperty
	a_ext_excl: assert property (p_ext_excl) else $error("both codec flags set");
	// encoder depends on its data alone
	property p_enc_stable;
		$past(rstn) && $stable(ext_enc_data) |=> $stable(ext_enc_check);
	endproperty
	a_enc_stable: assert property (p_enc_stable) else $error("check bits moved");
	// decoder depends on its word alone
	property p_dec_stable;
		$past(rstn) && $stable({ext_dec_data, ext_dec_check})
			|=> $stable({ext_dec_fixed, ext_sbe, ext_dbe});
	endproperty
	a_dec_stable: assert property (p_dec_stable) else $error("decoder moved");
endmodule : dpbrf_tile_chk

/* tb/dpbrf_fabric.sv */
`timescale 1ns/1ps
// ******************************
// fabric logic on one tile port
// ******************************
module dpbrf_fabric import dpbrf_pkg::*; (
	input wire logic clk,
	output logic en,
	output logic we,
	output logic [ADDR_W:0] addr,
	output logic [DATA_W-1:0] din,
	output dpbrf_width_type width,
	output dpbrf_wmode_type wmode,
	output logic oreg,
	input wire logic [DATA_W-1:0] dout
);
	// idle port from time zero
	initial begin
		en = 1'b0;
		we = 1'b0;
		addr = '0;
		din = '0;
		width = W72;
		wmode = READ_FIRST;
		oreg = 1'b0;
	end

	// one access on falling edges; read data taken after each output stage
	task automatic access(input logic w, input logic [ADDR_W:0] a, input logic [DATA_W-1:0] d,
		input dpbrf_width_type wd, input dpbrf_wmode_type m, input logic o,
		output logic [DATA_W-1:0] r1, output logic [DATA_W-1:0] r2);
		@(negedge clk);
		en = 1'b1;
		we = w;
		addr = a;
		din = d;
		width = wd;
		wmode = m;
		oreg = o;
		@(negedge clk);
		en = 1'b0;
		// released lines flip so a stale value never passes for a live one
		we = ~w;
		addr = ~a;
		din = ~d;
		@(negedge clk);
		r1 = dout;
		r2 = dout;
		if (o) begin
			@(negedge clk);
			r2 = dout;
		end
	endtask : access
endmodule : dpbrf_fabric

/* tb/dpbrf_tile_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) check_val(72'(g), 72'(e))
// *************************
// bench for the memory tile
// *************************
module dpbrf_tile_bench import dpbrf_pkg::*;;
	logic clk, rstn, fifo_mode, ecc_en, sleep, a_en, a_we, a_out_reg, b_en, b_we, b_out_reg;
	logic ecc_sbe, ecc_dbe, ext_sbe, ext_dbe, fifo_full, fifo_empty, fifo_prog_full;
	logic fifo_prog_empty;
	logic split_mode, one_read_one_write_mode;
	logic [12:0] prog_full_thresh, prog_empty_thresh;
	logic [ECC_DW-1:0] ext_enc_data, ext_dec_data, ext_dec_fixed, d;
	logic [ECC_CW-1:0] ext_dec_check, ext_enc_check;
	logic [ADDR_W:0] a_addr, b_addr;
	logic [DATA_W-1:0] a_din, b_din, a_dout, b_dout, a_casc_out, b_casc_out;
	logic [DATA_W-1:0] r1, r2, w, x, mem, outp, ex;
	dpbrf_width_type a_width, b_width;
	dpbrf_wmode_type a_wmode, b_wmode;
	dpbrf_wmode_type wm [4] = '{READ_FIRST, READ_FIRST, WRITE_FIRST, NO_CHANGE};
	logic [71:0] em [6] = '{72'h0, 72'h1, 72'h0_8000000000000000, 72'h4_0, 72'h3, 72'h40_20};
	logic [1:0] ef [6] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
	int error_cnt = 0;
	int check_count = 0;
	// bits that a 36-bit shape keeps: four data bytes and their parity
	localparam logic [71:0] M36 = 72'h0f_0000_0000_ffff_ffff;

	dpbrf_tile i_dpbrf_tile (
		.clk, .rstn, .split_mode, .one_read_one_write_mode, .fifo_mode, .ecc_en,
		.addr_latch_off(1'b0), .sleep, .casc_en(1'b0), .casc_upper(1'b0),
		.a_en, .a_we, .a_addr, .a_din, .a_width, .a_wmode, .a_out_reg, .a_casc_in(b_casc_out),
		.a_dout, .a_casc_out, .b_en, .b_we, .b_addr, .b_din, .b_width, .b_wmode, .b_out_reg,
		.b_casc_in(a_casc_out), .b_dout, .b_casc_out, .ecc_sbe, .ecc_dbe, .prog_full_thresh,
		.prog_empty_thresh, .fifo_full, .fifo_empty, .fifo_prog_full, .fifo_prog_empty,
		.ext_enc_data, .ext_enc_check, .ext_dec_data, .ext_dec_check, .ext_dec_fixed,
		.ext_sbe, .ext_dbe
	);
	dpbrf_fabric i_fab_a (.clk, .en(a_en), .we(a_we), .addr(a_addr), .din(a_din),
		.width(a_width), .wmode(a_wmode), .oreg(a_out_reg), .dout(a_dout));
	dpbrf_fabric i_fab_b (.clk, .en(b_en), .we(b_we), .addr(b_addr), .din(b_din),
		.width(b_width), .wmode(b_wmode), .oreg(b_out_reg), .dout(b_dout));

	// ********************
	// helpers
	// ********************
	function automatic logic [71:0] pat(input int i);
		return {8'(i), 32'(i * 7), ~32'(i)};
	endfunction : pat

	task automatic check_val(input logic [71:0] got, input logic [71:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard, about two and a half times the expected run
	initial begin
		repeat (8000) @(posedge clk);
		error_cnt++;
		final_report();
	end

	// ********************
	// tests
	// ********************
	initial begin
		rstn = 1'b0;
		fifo_mode = 1'b0;
		split_mode = 1'b0;
		one_read_one_write_mode = 1'b0;
		ecc_en = 1'b0;
		sleep = 1'b0;
		prog_full_thresh = 13'h0100;
		prog_empty_thresh = 13'h0040;
		ext_enc_data = '0;
		ext_dec_data = '0;
		ext_dec_check = '0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		`CHK(a_dout, 0);
		`CHK(b_dout, 0);
		`CHK({fifo_empty, fifo_prog_empty, fifo_full, fifo_prog_full}, 4'hc);
		$display("test reset done");
		// write policies on one location, then a pipelined read on the other port
		outp = '0;
		for (int i = 0; i < 4; i++) begin
			w = {8'(i), 64'h0123456789abcdef ^ 64'(i * 32'h11111111)};
			i_fab_a.access(1'b1, '0, w, W72, wm[i], 1'b0, r1, r2);
			// outside the wide mode a 72-bit request falls back to 36 bits
			ex = wm[i] == READ_FIRST ? mem : wm[i] == WRITE_FIRST ? w & M36 : outp;
			if (i > 0) `CHK(r1, ex);
			mem = w & M36;
			outp = ex;
		end
		i_fab_b.access(1'b0, '0, '0, W72, READ_FIRST, 1'b1, r1, r2);
		`CHK(r1, 0);
		`CHK(r2, mem);
		`CHK(a_casc_out, outp);
		`CHK(b_casc_out, mem);
		$display("test policies done");
		// one wide word read back through narrow shapes
		// full 72-bit words need the one-read-one-write mode from here on
		one_read_one_write_mode = 1'b1;
		x = 72'h9c_fedcba98_76543210;
		i_fab_a.access(1'b1, 16'd1, x, W72, READ_FIRST, 1'b0, r1, r2);
		i_fab_b.access(1'b0, 16'd68, '0, W1, READ_FIRST, 1'b0, r1, r2);
		`CHK(r1[0], x[4]);
		i_fab_b.access(1'b0, 16'd38, '0, W2, READ_FIRST, 1'b0, r1, r2);
		`CHK(r1[1:0], x[13:12]);
		i_fab_b.access(1'b0, 16'd18, '0, W4, READ_FIRST, 1'b0, r1, r2);
		`CHK(r1[3:0], x[11:8]);
		i_fab_b.access(1'b0, 16'd3, '0, W36, READ_FIRST, 1'b0, r1, r2);
		`CHK({r1[67:64], r1[31:0]}, {x[71:68], x[63:32]});
		$display("test shapes done");
		// write while gated must be lost
		sleep = 1'b1;
		i_fab_a.access(1'b1, 16'd1, ~x, W72, READ_FIRST, 1'b0, r1, r2);
		repeat (2) @(negedge clk);
		sleep = 1'b0;
		i_fab_b.access(1'b0, 16'd1, '0, W72, READ_FIRST, 1'b0, r1, r2);
		`CHK(r1, x);
		$display("test sleep done");
		// stored check bits, then single and double flips injected raw
		d = 64'h0f1e2d3c4b5a6978;
		ecc_en = 1'b1;
		i_fab_a.access(1'b1, 16'd2, {8'h00, d}, W72, READ_FIRST, 1'b0, r1, r2);
		ecc_en = 1'b0;
		i_fab_b.access(1'b0, 16'd2, '0, W72, READ_FIRST, 1'b0, x, r2);
		`CHK(x[63:0], d);
		for (int i = 0; i < 2; i++) begin
			ecc_en = 1'b0;
			w = {x[71:64], d ^ (i == 0 ? 64'h200 : 64'h3)};
			i_fab_a.access(1'b1, 16'd2, w, W72, READ_FIRST, 1'b0, r1, r2);
			ecc_en = 1'b1;
			i_fab_b.access(1'b0, 16'd2, '0, W72, READ_FIRST, 1'b0, r1, r2);
			`CHK({ecc_sbe, ecc_dbe}, i == 0 ? 2'h2 : 2'h1);
			if (i == 0) `CHK(r1[63:0], d);
		end
		ecc_en = 1'b0;
		// standalone codec on an external word
		ext_enc_data = d;
		@(negedge clk);
		for (int i = 0; i < 6; i++) begin
			{ext_dec_check, ext_dec_data} = {ext_enc_check, d} ^ em[i];
			@(negedge clk);
			`CHK({ext_sbe, ext_dbe}, ef[i]);
			if (!ef[i][0]) `CHK(ext_dec_fixed, d);
		end
		$display("test ecc done");
		// fill past full, then drain past empty
		fifo_mode = 1'b1;
		for (int i = 0; i < 513; i++) begin
			i_fab_a.access(1'b1, '0, pat(i), W72, READ_FIRST, 1'b0, r1, r2);
			`CHK(fifo_prog_full, (i + 1) * 8 >= 256);
			`CHK(fifo_prog_empty, (i + 1) * 8 <= 64);
			`CHK(fifo_full, i >= 511);
		end
		for (int i = 0; i < 513; i++) begin
			i_fab_b.access(1'b0, '0, '0, W72, READ_FIRST, 1'b0, r1, r2);
			`CHK(r1, pat(i < 512 ? i : 511));
			`CHK(fifo_empty, i >= 511);
		end
		$display("test fifo done");
		// split halves keep apart even at the same address
		fifo_mode = 1'b0;
		one_read_one_write_mode = 1'b0;
		split_mode = 1'b1;
		i_fab_b.access(1'b1, '0, ~x, W36, READ_FIRST, 1'b0, r1, r2);
		i_fab_a.access(1'b1, '0, x, W36, READ_FIRST, 1'b0, r1, r2);
		i_fab_b.access(1'b0, '0, '0, W36, READ_FIRST, 1'b0, r1, r2);
		`CHK(r1, ~x & M36);
		i_fab_a.access(1'b0, '0, '0, W36, READ_FIRST, 1'b0, r1, r2);
		`CHK(r1, x & M36);
		$display("test split done");
		final_report();
	end
endmodule : dpbrf_tile_bench

bind dpbrf_tile dpbrf_tile_chk i_chk (
	.clk, .rstn, .one_read_one_write_mode, .fifo_mode, .sleep, .casc_en, .a_en, .a_we,
	.a_wmode, .a_out_reg, .a_dout, .b_en, .b_dout, .ecc_sbe, .ecc_dbe, .prog_full_thresh,
	.prog_empty_thresh, .fifo_full, .fifo_empty, .fifo_prog_full, .fifo_prog_empty,
	.ext_enc_data, .ext_enc_check, .ext_dec_data, .ext_dec_check, .ext_dec_fixed,
	.ext_sbe, .ext_dbe
);
